//--- src/cfb_exec.v
// Execution stage for delayed true-branch, flag clears, compares and divide setup.
// Assumes one instruction offered per cycle with instr_valid, operands read combinationally
// by register index, and a fetch unit that follows pc_q and the redirect pulse.
`timescale 1ns/1ps
`include "cfb_exec_defines.vh"

// Operation
// - Opcode 10001101 plus displacement branches only when test flag is one.
// - Displacement sign-extended, doubled, added to branch address plus four.
// - Branch instruction's own address is the target base.
// - Taken branch runs the following slot instruction before the target.
// - No interrupt accepted between the branch and its slot.
// - Branch in delay slot raises slot-illegal exception instead of running.
// - Accumulator clear zeroes both halves in one cycle, test flag kept.
// - Saturation clear zeroes the saturation flag, test flag kept.
// - Test-flag clear writes zero to the test flag.
// - Compares set test flag on true, clear on false, registers untouched.
// - Pattern 0011nnnnmmmm0000 tests register equality.
// - Signed greater-equal and greater compare destination against source.
// - Unsigned higher and higher-same compare destination against source.
// - Positive and nonnegative compare a signed register with zero.
// - Byte-match compare sets flag when any byte lane matches.
// - Immediate compare sign-extends byte, compares with register zero.
// - Signed divide setup copies sign bits, test flag gets their xor.
// - Unsigned divide setup zeroes divisor-sign, quotient and test flags.
module cfb_exec #(
  parameter W          = 32,
  parameter RESET_PC   = 32'h0000_0000
) (
  input  wire         mclk,
  input  wire         rst_b,
  input  wire         instr_valid,
  input  wire [15:0]  instr,
  input  wire         other_branch,
  input  wire         irq_pending,
  input  wire [W-1:0] dst_val,
  input  wire [W-1:0] src_val,
  input  wire [W-1:0] zero_val,
  output wire [3:0]   dst_sel,
  output wire [3:0]   src_sel,
  output reg  [W-1:0] pc_q,
  output reg          redirect_q,
  output reg          test_flag_q,
  output reg          sat_flag_q,
  output reg          quot_flag_q,
  output reg          dsign_flag_q,
  output reg  [W-1:0] accum_high_word_q,
  output reg  [W-1:0] accum_low_word_q,
  output reg          in_slot_q,
  output reg          slot_illegal_q,
  output wire         irq_accept
);
  // Slot tracking states
  localparam ST_NORMAL = 1'b0;
  localparam ST_SLOT   = 1'b1;

  reg          state_q;
  reg          state_d;
  reg  [W-1:0] target_q;
  reg  [W-1:0] target_d;
  reg  [W-1:0] pc_d;
  reg          redirect_d;
  reg          test_d;
  reg          sat_d;
  reg          quot_d;
  reg          dsign_d;
  reg  [W-1:0] acc_hi_d;
  reg  [W-1:0] acc_lo_d;
  reg          illegal_d;
  wire         is_cmp;
  wire         cmp_cond;
  wire         is_bts;
  wire         is_branch;
  wire [W-1:0] disp_x2;

  assign dst_sel = instr[`FLD_RN_HI:`FLD_RN_LO];
  assign src_sel = instr[`FLD_RM_HI:`FLD_RM_LO];

  assign is_bts    = (instr & `OP_BTS_MASK) == `OP_BTS_VAL;
  assign is_branch = is_bts | other_branch;

  assign disp_x2 = {{(W-9){instr[`FLD_SIGN]}}, instr[`FLD_DISP_HI:0], 1'b0};

  // interrupts held off while the slot is pending
  assign irq_accept = irq_pending & (state_q == ST_NORMAL) & ~(instr_valid & is_bts & test_flag_q);

  cfb_cond_unit #(
    .W        (W)
  ) u_cond (
    .instr    (instr),
    .dst_val  (dst_val),
    .src_val  (src_val),
    .zero_val (zero_val),
    .is_cmp   (is_cmp),
    .cond     (cmp_cond)
  );

  // Next-state and flag update; one instruction retires per valid cycle
  always @*
  begin
    state_d    = state_q;
    target_d   = target_q;
    pc_d       = pc_q;
    redirect_d = 1'b0;
    test_d     = test_flag_q;
    sat_d      = sat_flag_q;
    quot_d     = quot_flag_q;
    dsign_d    = dsign_flag_q;
    acc_hi_d   = accum_high_word_q;
    acc_lo_d   = accum_low_word_q;
    illegal_d  = 1'b0;
    if (instr_valid)
    begin
      case (state_q)
        ST_NORMAL:
        begin
          pc_d = pc_q + `PC_STEP;
          if (is_bts && test_flag_q)
          begin
            // base is the branch's own address
            target_d = pc_q + `PC_BR_OFS + disp_x2;
            state_d  = ST_SLOT;
          end
          else if (instr == `OP_ACCUMULATOR_CLEAR_OP)
          begin
            acc_hi_d = {W{1'b0}};
            acc_lo_d = {W{1'b0}};
          end
          else if (instr == `OP_SATURATION_FLAG_CLEAR_OP)
            sat_d = 1'b0;
          else if (instr == `OP_TEST_FLAG_CLEAR_OP)
            test_d = 1'b0;
          else if (instr == `OP_UNSIGNED_DIVIDE_SETUP)
          begin
            dsign_d = 1'b0;
            quot_d  = 1'b0;
            test_d  = 1'b0;
          end
          else if ((instr & `OP_RR_MASK) == `OP_SIGNED_DIVIDE_SETUP_VAL)
          begin
            quot_d  = dst_val[W-1];
            dsign_d = src_val[W-1];
            test_d  = dst_val[W-1] ^ src_val[W-1];
          end
          else if (is_cmp)
            test_d = cmp_cond;
        end
        ST_SLOT:
        begin
          state_d = ST_NORMAL;
          if (is_branch)
          begin
            // branch in slot is illegal; pc left for the trap logic
            illegal_d = 1'b1;
          end
          else
          begin
            pc_d       = target_q;
            redirect_d = 1'b1;
            if (instr == `OP_ACCUMULATOR_CLEAR_OP)
            begin
              acc_hi_d = {W{1'b0}};
              acc_lo_d = {W{1'b0}};
            end
            else if (instr == `OP_SATURATION_FLAG_CLEAR_OP)
              sat_d = 1'b0;
            else if (instr == `OP_TEST_FLAG_CLEAR_OP)
              test_d = 1'b0;
            else if (instr == `OP_UNSIGNED_DIVIDE_SETUP)
            begin
              dsign_d = 1'b0;
              quot_d  = 1'b0;
              test_d  = 1'b0;
            end
            else if ((instr & `OP_RR_MASK) == `OP_SIGNED_DIVIDE_SETUP_VAL)
            begin
              quot_d  = dst_val[W-1];
              dsign_d = src_val[W-1];
              test_d  = dst_val[W-1] ^ src_val[W-1];
            end
            else if (is_cmp)
              test_d = cmp_cond;
          end
        end
        default:
          state_d = ST_NORMAL;
      endcase
    end
  end

  // State registers; flags reset to zero
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q           <= ST_NORMAL;
      target_q          <= {W{1'b0}};
      pc_q              <= RESET_PC;
      redirect_q        <= 1'b0;
      test_flag_q       <= 1'b0;
      sat_flag_q        <= 1'b0;
      quot_flag_q       <= 1'b0;
      dsign_flag_q      <= 1'b0;
      accum_high_word_q <= {W{1'b0}};
      accum_low_word_q  <= {W{1'b0}};
      in_slot_q         <= 1'b0;
      slot_illegal_q    <= 1'b0;
    end
    else
    begin
      state_q           <= state_d;
      target_q          <= target_d;
      pc_q              <= pc_d;
      redirect_q        <= redirect_d;
      test_flag_q       <= test_d;
      sat_flag_q        <= sat_d;
      quot_flag_q       <= quot_d;
      dsign_flag_q      <= dsign_d;
      accum_high_word_q <= acc_hi_d;
      accum_low_word_q  <= acc_lo_d;
      in_slot_q         <= state_d;
      slot_illegal_q    <= illegal_d;
    end
  end
endmodule

//--- inc/cfb_exec_defines.vh
// Encodings and field positions for the compare, flag-clear and delayed-branch execution block.
// Assumes 16-bit instruction words and 32-bit general registers.
`ifndef CFB_EXEC_DEFINES_VH
`define CFB_EXEC_DEFINES_VH

// Opcode matches: mask and value pairs
`define OP_BTS_MASK    16'hFF00
`define OP_BTS_VAL     16'h8D00
`define OP_CMPIMM_MASK 16'hFF00
`define OP_CMPIMM_VAL  16'h8800
`define OP_RR_MASK     16'hF00F
`define OP_EQ_VAL      16'h3000
`define OP_HS_VAL      16'h3002
`define OP_GE_VAL      16'h3003
`define OP_HI_VAL      16'h3006
`define OP_GT_VAL      16'h3007
`define OP_SIGNED_DIVIDE_SETUP_VAL   16'h2007
`define OP_STR_VAL     16'h200C
`define OP_R1_MASK     16'hF0FF
`define OP_PZ_VAL      16'h4011
`define OP_PL_VAL      16'h4015
`define OP_ACCUMULATOR_CLEAR_OP      16'h0028
`define OP_SATURATION_FLAG_CLEAR_OP        16'h0048
`define OP_TEST_FLAG_CLEAR_OP        16'h0008
`define OP_UNSIGNED_DIVIDE_SETUP       16'h0019

// Field positions
`define FLD_RN_HI   11
`define FLD_RN_LO   8
`define FLD_RM_HI   7
`define FLD_RM_LO   4
`define FLD_DISP_HI 7
`define FLD_SIGN    7

// Program counter steps in bytes
`define PC_STEP   32'h0000_0002
`define PC_BR_OFS 32'h0000_0004

`endif

//--- src/cfb_cond_unit.v
// Condition evaluator for the nine compare forms; signed divide setup is decoded in cfb_exec itself.
// Assumes operands already read from the register file in the same cycle.
`timescale 1ns/1ps
`include "cfb_exec_defines.vh"

module cfb_cond_unit #(
  parameter W = 32
) (
  input  wire [15:0]  instr,
  input  wire [W-1:0] dst_val,
  input  wire [W-1:0] src_val,
  input  wire [W-1:0] zero_val,
  output reg          is_cmp,
  output reg          cond
);
  wire [W-1:0] diff  = dst_val ^ src_val;
  wire [W-1:0] imm_x = {{(W-8){instr[`FLD_SIGN]}}, instr[`FLD_DISP_HI:0]};
  wire         s_ge  = $signed(dst_val) >= $signed(src_val);
  wire         s_gt  = $signed(dst_val) >  $signed(src_val);
  wire         u_ge  = dst_val >= src_val;
  wire         u_gt  = dst_val >  src_val;
  wire         nz    = |dst_val;

  // Pick the condition by opcode pattern; no match means not a compare
  always @*
  begin
    is_cmp = 1'b1;
    cond   = 1'b0;
    if ((instr & `OP_RR_MASK) == `OP_EQ_VAL)
      cond = (diff == {W{1'b0}});
    else if ((instr & `OP_RR_MASK) == `OP_GE_VAL)
      cond = s_ge;
    else if ((instr & `OP_RR_MASK) == `OP_GT_VAL)
      cond = s_gt;
    else if ((instr & `OP_RR_MASK) == `OP_HI_VAL)
      cond = u_gt;
    else if ((instr & `OP_RR_MASK) == `OP_HS_VAL)
      cond = u_ge;
    else if ((instr & `OP_R1_MASK) == `OP_PL_VAL)
      cond = ~dst_val[W-1] & nz;
    else if ((instr & `OP_R1_MASK) == `OP_PZ_VAL)
      cond = ~dst_val[W-1];
    else if ((instr & `OP_RR_MASK) == `OP_STR_VAL)
      cond = (diff[31:24] == 8'h00) | (diff[23:16] == 8'h00) |
             (diff[15:8] == 8'h00) | (diff[7:0] == 8'h00);
    else if ((instr & `OP_CMPIMM_MASK) == `OP_CMPIMM_VAL)
      cond = (zero_val == imm_x);
    else
      is_cmp = 1'b0;
  end
endmodule

//--- testbench/cfb_exec_props.sv
// Port-level checker for the compare, flag-clear and delayed-branch execution stage.
// Assumes one clock domain and bind onto the stage from the bench top.
`timescale 1ns/1ps
module cfb_exec_props #(
  parameter W = 32
) (
  input logic         mclk,
  input logic         rst_b,
  input logic         instr_valid,
  input logic [15:0]  instr,
  input logic         other_branch,
  input logic         irq_pending,
  input logic [W-1:0] dst_val,
  input logic [W-1:0] src_val,
  input logic [W-1:0] zero_val,
  input logic [3:0]   dst_sel,
  input logic [3:0]   src_sel,
  input logic [W-1:0] pc_q,
  input logic         redirect_q,
  input logic         test_flag_q,
  input logic         sat_flag_q,
  input logic         quot_flag_q,
  input logic         dsign_flag_q,
  input logic [W-1:0] accum_high_word_q,
  input logic [W-1:0] accum_low_word_q,
  input logic         in_slot_q,
  input logic         slot_illegal_q,
  input logic         irq_accept
);
  logic [W-1:0] tgt_q;
  wire          bts   = instr_valid && instr[15:8] == 8'h8D;
  wire          taken = bts && test_flag_q && !in_slot_q;
  // Target kept aside, since the slot cycle moves the program counter first
  always_ff @(posedge mclk)
    if (taken) tgt_q <= pc_q + 4 + {{(W-9){instr[7]}}, instr[7:0], 1'b0};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_taken; taken; endsequence
  sequence s_slot_ok; instr_valid && in_slot_q && !bts && !other_branch; endsequence
  // A refused slot instruction has no effect, so flag checks skip it
  wire          runs  = instr_valid && !(in_slot_q && other_branch);
  a_slot_follows: assert property (s_taken |=> in_slot_q && pc_q == $past(pc_q) + 2)
    else $error("slot not entered after taken branch");
  a_branch_target: assert property (s_taken ##1 s_slot_ok |=> redirect_q && pc_q == tgt_q)
    else $error("wrong branch target");
  a_untaken_seq: assert property (bts && !test_flag_q && !in_slot_q |=> !in_slot_q && !redirect_q)
    else $error("untaken branch opened a slot");
  a_irq_gate: assert property (irq_accept == (irq_pending && !in_slot_q && !taken))
    else $error("interrupt accepted inside branch pair");
  a_slot_illegal: assert property (in_slot_q && instr_valid && (bts || other_branch)
    |=> slot_illegal_q && !redirect_q && !in_slot_q && $stable(pc_q))
    else $error("branch in slot not refused");
  a_mac_clear: assert property (runs && instr == 16'h0028
    |=> accum_high_word_q == 0 && accum_low_word_q == 0 && $stable(test_flag_q))
    else $error("accumulator clear wrong");
  a_sat_clear: assert property (runs && instr == 16'h0048 |=> !sat_flag_q && $stable(test_flag_q))
    else $error("saturation clear wrong");
  a_flag_clear: assert property (runs && instr == 16'h0008 |=> !test_flag_q)
    else $error("test flag clear wrong");
  a_udiv_setup: assert property (runs && instr == 16'h0019
    |=> !test_flag_q && !quot_flag_q && !dsign_flag_q)
    else $error("unsigned divide setup wrong");
  a_pc_step: assert property (instr_valid && !in_slot_q && !bts |=> pc_q == $past(pc_q) + 2)
    else $error("program counter step wrong");
endmodule

//--- testbench/tb_cfb_exec.sv
// Self-checking bench for the execution stage against an in-bench model.
// Assumes the stage and its defines header are compiled ahead of this file.
`timescale 1ns/1ps
module tb_cfb_exec;
  localparam logic [31:0] PC0 = 32'h0000_0100;
  logic        mclk, rst_b, instr_valid, other_branch, irq_pending;
  logic [15:0] instr, op;
  logic [31:0] dst_val, src_val, zero_val, pc_q, accum_high_word_q, accum_low_word_q, d, m_pc, m_tgt;
  logic [3:0]  dst_sel, src_sel;
  logic        redirect_q, test_flag_q, sat_flag_q, quot_flag_q, dsign_flag_q, in_slot_q, slot_illegal_q;
  logic        irq_accept, m_t, m_q, m_m, m_slot, m_red, m_ill;
  int          failures, check_count;
  logic [15:0] ops [15] = '{16'h3000, 16'h3002, 16'h3003, 16'h3006, 16'h3007, 16'h200C, 16'h2007, 16'h4011,
                            16'h4015, 16'h8800, 16'h8D00, 16'h0008, 16'h0019, 16'h0028, 16'h0048};
  logic [15:0] dir [14] = '{16'h3000, 16'h8D7F, 16'h3000, 16'h8D80, 16'h3000, 16'h8D80, 16'h8D01, 16'h3000,
                            16'h8D02, 16'h0028, 16'h0048, 16'h0008, 16'h0019, 16'h2007};
  cfb_exec #(.RESET_PC(PC0)) dut (.*);
  // Free-running clock, 4 ns period
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One instruction slot: drive, check settled outputs, then advance the model
  task automatic step(input logic v, input logic [15:0] o, input logic ob, input logic irq,
                      input logic [31:0] a, input logic [31:0] s, input logic [31:0] z);
    logic bts, tk, bad;
    @(posedge mclk);
    instr_valid <= v; instr <= o; other_branch <= ob; irq_pending <= irq;
    dst_val <= a; src_val <= s; zero_val <= z;
    @(negedge mclk);
    bts = o[15:8] == 8'h8D;
    tk = v && bts && m_t && !m_slot;
    bad = v && m_slot && (bts || ob);
    chk(pc_q, m_pc);
    chk({test_flag_q, quot_flag_q, dsign_flag_q, sat_flag_q}, {m_t, m_q, m_m, 1'b0});
    chk(accum_high_word_q | accum_low_word_q, 32'h0);
    chk({redirect_q, in_slot_q, slot_illegal_q}, {m_red, m_slot, m_ill});
    chk(irq_accept, irq && !m_slot && !tk);
    chk({dst_sel, src_sel}, o[11:4]);
    m_red = 0;
    m_ill = bad;
    if (v && !bad)
    begin
      casez (o)
        16'h0008: m_t = 0;
        16'h0019: {m_q, m_m, m_t} = 3'h0;
        16'h3??0: m_t = a == s;
        16'h3??2: m_t = a >= s;
        16'h3??3: m_t = $signed(a) >= $signed(s);
        16'h3??6: m_t = a > s;
        16'h3??7: m_t = $signed(a) > $signed(s);
        16'h2??C: m_t = a[31:24] == s[31:24] || a[23:16] == s[23:16] || a[15:8] == s[15:8] || a[7:0] == s[7:0];
        16'h2??7: {m_q, m_m, m_t} = {a[31], s[31], a[31] ^ s[31]};
        16'h4?11: m_t = !a[31];
        16'h4?15: m_t = $signed(a) > 0;
        16'h88??: m_t = z == {{24{o[7]}}, o[7:0]};
        default: ;
      endcase
      m_red = m_slot;
      // Slot runs first, then the stored target takes over
      if (m_slot) m_pc = m_tgt;
      else m_pc = m_pc + 2;
      if (tk) m_tgt = m_pc + 2 + {{23{o[7]}}, o[7:0], 1'b0};
      m_slot = tk;
    end
    else if (bad) m_slot = 0;
  endtask
  // Watchdog for a stalled run
  initial
  begin
    repeat (50000) @(posedge mclk);
    failures++;
    finish_test();
  end
  initial
  begin
    {rst_b, instr_valid, instr, other_branch, irq_pending, dst_val, src_val, zero_val} = '0;
    {m_pc, m_tgt, m_t, m_q, m_m, m_slot, m_red, m_ill} = {PC0, 32'h0, 6'h0};
    void'($urandom(32'h0BBACF17));
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (dir[i]) step(1'b1, dir[i], i == 9, 1'b1, (i == 2) ? 32'h1 : 32'h5, 32'h5, 32'h0);
    repeat (3000)
    begin
      op = ops[$urandom % 15];
      op = op | ($urandom & (op[15] ? 16'h00FF : op[14] ? 16'h0F00 : op[13] ? 16'h0FF0 : 16'h0000));
      d = $urandom;
      step($urandom % 8 != 0, op, $urandom % 16 == 0, $urandom, d,
           ($urandom % 3 == 0) ? d : ($urandom % 2) ? d ^ 32'hFF00_FF00 : $urandom,
           ($urandom % 2) ? {{24{op[7]}}, op[7:0]} : $urandom);
    end
    finish_test();
  end
endmodule
bind cfb_exec cfb_exec_props #(.W(W)) u_props (.*);
